// ===== logic/omc_pkg.sv
// Constants, register map and state types for the operating mode control block
package omc_pkg;
	// Register byte offsets
	localparam logic [11:0] ADDR_CTRL    = 12'h000;
	localparam logic [11:0] ADDR_THRESH  = 12'h004;
	localparam logic [11:0] ADDR_STATUS  = 12'h008;
	localparam logic [11:0] ADDR_IRQ_ST  = 12'h00C;
	localparam logic [11:0] ADDR_IRQ_CLR = 12'h010;
	localparam logic [11:0] ADDR_IRQ_EN  = 12'h014;
	// Control fields
	localparam int CTRL_DIS0  = 0;
	localparam int CTRL_DIS1  = 1;
	localparam int CTRL_CUR0  = 2;
	localparam int CTRL_CUR1  = 3;
	localparam int CTRL_PLRD0 = 4;
	localparam int CTRL_PLRD1 = 5;
	localparam logic [5:0]  CTRL_RESET   = 6'h03;
	localparam logic [15:0] THRESH_RESET = 16'hFFFF;
	localparam logic [7:0]  OVC_MAX_CODE = 8'hFF;
	// Status fields
	localparam int ST_MCU    = 0;
	localparam int ST_SEL    = 1;
	localparam int ST_MOPEN  = 2;
	localparam int ST_SOPEN  = 3;
	localparam int ST_STBY   = 4;
	localparam int ST_ON0    = 5;
	localparam int ST_ON1    = 6;
	localparam int ST_TRIP0  = 7;
	localparam int ST_TRIP1  = 8;
	localparam int ST_FAULT  = 9;
	// Interrupt event bits
	localparam int IRQ_W     = 6;
	localparam int EV_OPEN   = 0;
	localparam int EV_TRIP0  = 1;
	localparam int EV_TRIP1  = 2;
	localparam int EV_OVT    = 3;
	localparam int EV_PDN    = 4;
	localparam int EV_WAKE   = 5;
	localparam logic [IRQ_W-1:0] IRQ_EN_RESET = 6'h00;
	// Synchroniser lane positions
	localparam int SYN_W     = 11;
	localparam int SY_MODE   = 0;
	localparam int SY_SEL    = 1;
	localparam int SY_MOPEN  = 2;
	localparam int SY_SOPEN  = 3;
	localparam int SY_OVC0   = 4;
	localparam int SY_OVC1   = 5;
	localparam int SY_OVT    = 6;
	localparam int SY_PDN    = 7;
	localparam int SY_EC0    = 8;
	localparam int SY_EC1    = 9;
	localparam int SY_WAKE   = 10;
	// Power state, Gray coded along reset, run, standby, wake
	typedef enum logic [1:0]
	{
		PS_RESET = 2'b00,
		PS_RUN   = 2'b01,
		PS_STBY  = 2'b11,
		PS_WAKE  = 2'b10
	} omc_pstate_t;
	// Byte-lane merge for APB writes
	function automatic logic [31:0] omc_merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] strb);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++)
		begin
			if (strb[i])
				r[i*8 +: 8] = new_v[i*8 +: 8];
		end
		return r;
	endfunction
	// Address is one of the mapped words
	function automatic logic omc_hit(input logic [11:0] a);
		return (a == ADDR_CTRL) || (a == ADDR_THRESH) || (a == ADDR_STATUS) ||
			(a == ADDR_IRQ_ST) || (a == ADDR_IRQ_CLR) || (a == ADDR_IRQ_EN);
	endfunction
endpackage

// ===== logic/omc_sync.sv
// Two-flop synchroniser for a vector of pin levels
module omc_sync #(
	parameter int W = 1
) (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);
	logic [W-1:0] meta_reg;
	logic [W-1:0] meta_next;
	logic [W-1:0] sync_reg;
	logic [W-1:0] sync_next;

	// First stage feeds only the second
	always_comb
	begin
		meta_next = async_in;
		sync_next = meta_reg;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			meta_reg <= '0;
			sync_reg <= '0;
		end
		else
		begin
			meta_reg <= meta_next;
			sync_reg <= sync_next;
		end
	end

	assign sync_out = sync_reg;
endmodule

// ===== logic/omc_chan.sv
// One laser channel enable with latched trip and enable-pin re-arm
module omc_chan (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic enable_pin,
	input  wire logic inhibit,
	input  wire logic trip,
	output logic      laser_on,
	output logic      tripped
);
	logic on_reg;
	logic on_next;
	logic trip_reg;
	logic trip_next;

	// Trip sets over the pin-low clear so a fresh trip is never lost
	always_comb
	begin
		trip_next = trip_reg;
		if (trip)
			trip_next = 1'b1;
		else if (!enable_pin)
			trip_next = 1'b0;
		on_next = enable_pin && !inhibit && !trip_next;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			on_reg   <= 1'b0;
			trip_reg <= 1'b0;
		end
		else
		begin
			on_reg   <= on_next;
			trip_reg <= trip_next;
		end
	end

	assign laser_on = on_reg;
	assign tripped  = trip_reg;
endmodule

// ===== logic/omc_top.sv
// Operating mode control: strap decode, channel enables, standby, APB registers
module omc_top (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        mcu_mode_strap,
	input  wire logic        mcu_mode_strap_open,
	input  wire logic        interface_or_reference_strap,
	input  wire logic        interface_or_reference_strap_open,
	input  wire logic [1:0]  channel_enable_pin,
	input  wire logic [1:0]  overcurrent_detect,
	input  wire logic        overtemp_detect,
	input  wire logic        power_down_detect,
	input  wire logic        wake_control_pin,
	output logic             fault_indicator_n,
	output logic [1:0]       laser_on,
	output logic             mcu_mode,
	output logic             ref_half_volt,
	output logic             host_if_i2c,
	output logic             host_if_spi,
	output logic [1:0]       power_loop_mode,
	output logic [1:0]       current_loop_mode,
	output logic [1:0]       programmable_monitor_resistor_off,
	output logic [15:0]      overcurrent_threshold,
	output logic             standby,
	output logic             inputs_hiz,
	output logic             irq
);
	logic [omc_pkg::SYN_W-1:0] pin_raw;
	logic [omc_pkg::SYN_W-1:0] pin_s;
	logic                      strap_open;
	logic [1:0]                chan_on;
	logic [1:0]                chan_trip;
	logic [1:0]                chan_inhibit;
	logic [1:0]                chan_trip_in;
	logic                      power_off;

	// Every pin level passes the synchroniser before use
	assign pin_raw = {wake_control_pin, channel_enable_pin, power_down_detect,
		overtemp_detect, overcurrent_detect, interface_or_reference_strap_open,
		mcu_mode_strap_open, interface_or_reference_strap, mcu_mode_strap};

	omc_sync #(
		.W(omc_pkg::SYN_W)
	) u_sync (
		.pclk     (pclk),
		.presetn  (presetn),
		.async_in (pin_raw),
		.sync_out (pin_s)
	);

	assign strap_open = pin_s[omc_pkg::SY_MOPEN] | pin_s[omc_pkg::SY_SOPEN];

	// Power state
	omc_pkg::omc_pstate_t ps_reg;
	omc_pkg::omc_pstate_t ps_next;

	// Standby follows the wake pin alone; no other source can wake
	always_comb
	begin
		ps_next = ps_reg;
		case (ps_reg)
			omc_pkg::PS_RESET:
				ps_next = pin_s[omc_pkg::SY_WAKE] ? omc_pkg::PS_RUN : omc_pkg::PS_STBY;
			omc_pkg::PS_RUN:
				if (!pin_s[omc_pkg::SY_WAKE])
					ps_next = omc_pkg::PS_STBY;
			omc_pkg::PS_STBY:
				if (pin_s[omc_pkg::SY_WAKE])
					ps_next = omc_pkg::PS_WAKE;
			omc_pkg::PS_WAKE:
				ps_next = pin_s[omc_pkg::SY_WAKE] ? omc_pkg::PS_RUN : omc_pkg::PS_STBY;
			default:
				ps_next = omc_pkg::PS_RESET;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ps_reg <= omc_pkg::PS_RESET;
		else
			ps_reg <= ps_next;
	end

	// Lasers stay off until the run state, also through the wake cycle
	assign power_off = (ps_reg != omc_pkg::PS_RUN);

	// Configuration registers; standby never touches them
	logic [5:0]                 ctrl_reg;
	logic [5:0]                 ctrl_next;
	logic [15:0]                thr_reg;
	logic [15:0]                thr_next;
	logic [omc_pkg::IRQ_W-1:0]  ien_reg;
	logic [omc_pkg::IRQ_W-1:0]  ien_next;
	logic [omc_pkg::IRQ_W-1:0]  ist_reg;
	logic [omc_pkg::IRQ_W-1:0]  ist_next;
	logic [omc_pkg::IRQ_W-1:0]  ev_prev_reg;
	logic [omc_pkg::IRQ_W-1:0]  ev_prev_next;
	logic [omc_pkg::IRQ_W-1:0]  ev_lvl;
	logic [omc_pkg::IRQ_W-1:0]  ev_set;
	logic [omc_pkg::IRQ_W-1:0]  ev_clr;
	logic [31:0]                prdata_reg;
	logic [31:0]                prdata_next;
	logic [31:0]                rd_mux;
	logic [31:0]                wr_word;
	logic [31:0]                status_word;
	logic                       wr_en;
	logic                       addr_ok;

	assign addr_ok = omc_pkg::omc_hit(paddr);
	assign wr_en   = psel && penable && pwrite && addr_ok;
	// Merged write word; old bytes come from the read mux, which gives 0 for the clear word
	assign wr_word = omc_pkg::omc_merge(rd_mux, pwdata, pstrb);

	// Event levels; rising edges become sticky status bits
	always_comb
	begin
		ev_lvl = '0;
		ev_lvl[omc_pkg::EV_OPEN]  = strap_open;
		ev_lvl[omc_pkg::EV_TRIP0] = chan_trip[0];
		ev_lvl[omc_pkg::EV_TRIP1] = chan_trip[1];
		ev_lvl[omc_pkg::EV_OVT]   = pin_s[omc_pkg::SY_OVT];
		ev_lvl[omc_pkg::EV_PDN]   = pin_s[omc_pkg::SY_PDN];
		ev_lvl[omc_pkg::EV_WAKE]  = (ps_reg == omc_pkg::PS_WAKE);
		ev_set = ev_lvl & ~ev_prev_reg;
		ev_clr = '0;
		if (wr_en && paddr == omc_pkg::ADDR_IRQ_CLR)
			ev_clr = wr_word[omc_pkg::IRQ_W-1:0];
	end

	// Register writes; a new event beats a clear in the same cycle
	always_comb
	begin
		ctrl_next    = ctrl_reg;
		thr_next     = thr_reg;
		ien_next     = ien_reg;
		ev_prev_next = ev_lvl;
		ist_next     = (ist_reg & ~ev_clr) | ev_set;
		if (wr_en && paddr == omc_pkg::ADDR_CTRL)
			ctrl_next = wr_word[5:0];
		if (wr_en && paddr == omc_pkg::ADDR_THRESH)
			thr_next = wr_word[15:0];
		if (wr_en && paddr == omc_pkg::ADDR_IRQ_EN)
			ien_next = wr_word[omc_pkg::IRQ_W-1:0];
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_reg    <= omc_pkg::CTRL_RESET;
			thr_reg     <= omc_pkg::THRESH_RESET;
			ien_reg     <= omc_pkg::IRQ_EN_RESET;
			ist_reg     <= '0;
			ev_prev_reg <= '0;
		end
		else
		begin
			ctrl_reg    <= ctrl_next;
			thr_reg     <= thr_next;
			ien_reg     <= ien_next;
			ist_reg     <= ist_next;
			ev_prev_reg <= ev_prev_next;
		end
	end

	// Status word assembled from live state
	always_comb
	begin
		status_word = 32'h0000_0000;
		status_word[omc_pkg::ST_MCU]   = pin_s[omc_pkg::SY_MODE];
		status_word[omc_pkg::ST_SEL]   = pin_s[omc_pkg::SY_SEL];
		status_word[omc_pkg::ST_MOPEN] = pin_s[omc_pkg::SY_MOPEN];
		status_word[omc_pkg::ST_SOPEN] = pin_s[omc_pkg::SY_SOPEN];
		status_word[omc_pkg::ST_STBY]  = (ps_reg == omc_pkg::PS_STBY);
		status_word[omc_pkg::ST_ON0]   = chan_on[0];
		status_word[omc_pkg::ST_ON1]   = chan_on[1];
		status_word[omc_pkg::ST_TRIP0] = chan_trip[0];
		status_word[omc_pkg::ST_TRIP1] = chan_trip[1];
		status_word[omc_pkg::ST_FAULT] = !fault_indicator_n;
	end

	// Read data is captured in the setup cycle; the bus answers with no wait
	always_comb
	begin
		case (paddr)
			omc_pkg::ADDR_CTRL:   rd_mux = {26'h0, ctrl_reg};
			omc_pkg::ADDR_THRESH: rd_mux = {16'h0, thr_reg};
			omc_pkg::ADDR_STATUS: rd_mux = status_word;
			omc_pkg::ADDR_IRQ_ST: rd_mux = {26'h0, ist_reg};
			omc_pkg::ADDR_IRQ_EN: rd_mux = {26'h0, ien_reg};
			default:              rd_mux = 32'h0000_0000;
		endcase
		prdata_next = prdata_reg;
		if (psel && !penable)
			prdata_next = pwrite ? 32'h0000_0000 : rd_mux;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata_reg <= 32'h0000_0000;
		else
			prdata_reg <= prdata_next;
	end

	// Serial access is never blocked by a strap fault
	assign prdata  = prdata_reg;
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !addr_ok;

	// Channel gating; overtemperature latches like overcurrent
	assign chan_trip_in[0] = pin_s[omc_pkg::SY_OVC0] | pin_s[omc_pkg::SY_OVT];
	assign chan_trip_in[1] = pin_s[omc_pkg::SY_OVC1] | pin_s[omc_pkg::SY_OVT];
	assign chan_inhibit[0] = strap_open | power_off | pin_s[omc_pkg::SY_PDN] |
		ctrl_reg[omc_pkg::CTRL_DIS0];
	assign chan_inhibit[1] = strap_open | power_off | pin_s[omc_pkg::SY_PDN] |
		ctrl_reg[omc_pkg::CTRL_DIS1];

	for (genvar c = 0; c < 2; c++)
	begin : g_chan
		omc_chan u_chan (
			.pclk       (pclk),
			.presetn    (presetn),
			.enable_pin (pin_s[omc_pkg::SY_EC0 + c]),
			.inhibit    (chan_inhibit[c]),
			.trip       (chan_trip_in[c]),
			.laser_on   (chan_on[c]),
			.tripped    (chan_trip[c])
		);
	end

	// Decoded mode outputs, all registered
	logic        mcu_reg;
	logic        mcu_next;
	logic        refh_reg;
	logic        refh_next;
	logic        i2c_reg;
	logic        i2c_next;
	logic        spi_reg;
	logic        spi_next;
	logic [1:0]  apc_reg;
	logic [1:0]  apc_next;
	logic [1:0]  acc_reg;
	logic [1:0]  acc_next;
	logic [1:0]  plrd_reg;
	logic [1:0]  plrd_next;
	logic [15:0] othr_reg;
	logic [15:0] othr_next;
	logic        fault_n_reg;
	logic        fault_n_next;
	logic        irq_reg;
	logic        irq_next;
	logic        sel;

	assign sel = pin_s[omc_pkg::SY_SEL];

	// Straps are assumed static; a change mid-run retargets outputs three edges later, after the synchroniser and output register
	always_comb
	begin
		mcu_next  = pin_s[omc_pkg::SY_MODE];
		refh_next = !mcu_next && sel;
		i2c_next  = mcu_next && sel;
		spi_next  = mcu_next && !sel;
		acc_next  = mcu_next ? {ctrl_reg[omc_pkg::CTRL_CUR1], ctrl_reg[omc_pkg::CTRL_CUR0]}
			: 2'b00;
		apc_next  = ~acc_next;
		plrd_next = mcu_next ? {ctrl_reg[omc_pkg::CTRL_PLRD1], ctrl_reg[omc_pkg::CTRL_PLRD0]}
			: 2'b11;
		othr_next = mcu_next ? thr_reg : {omc_pkg::OVC_MAX_CODE, omc_pkg::OVC_MAX_CODE};
		fault_n_next = !(strap_open || (|chan_trip) || pin_s[omc_pkg::SY_OVT] ||
			pin_s[omc_pkg::SY_PDN]);
		irq_next  = |(ist_reg & ien_reg);
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mcu_reg     <= 1'b0;
			refh_reg    <= 1'b0;
			i2c_reg     <= 1'b0;
			spi_reg     <= 1'b0;
			apc_reg     <= 2'b11;
			acc_reg     <= 2'b00;
			plrd_reg    <= 2'b11;
			othr_reg    <= {omc_pkg::OVC_MAX_CODE, omc_pkg::OVC_MAX_CODE};
			fault_n_reg <= 1'b0;
			irq_reg     <= 1'b0;
		end
		else
		begin
			mcu_reg     <= mcu_next;
			refh_reg    <= refh_next;
			i2c_reg     <= i2c_next;
			spi_reg     <= spi_next;
			apc_reg     <= apc_next;
			acc_reg     <= acc_next;
			plrd_reg    <= plrd_next;
			othr_reg    <= othr_next;
			fault_n_reg <= fault_n_next;
			irq_reg     <= irq_next;
		end
	end

	assign fault_indicator_n                 = fault_n_reg;
	assign laser_on                          = chan_on;
	assign mcu_mode                          = mcu_reg;
	assign ref_half_volt                     = refh_reg;
	assign host_if_i2c                       = i2c_reg;
	assign host_if_spi                       = spi_reg;
	assign power_loop_mode                   = apc_reg;
	assign current_loop_mode                 = acc_reg;
	assign programmable_monitor_resistor_off = plrd_reg;
	assign overcurrent_threshold             = othr_reg;
	// Reset state counts as not yet awake, so inputs stay isolated
	assign standby                           = (ps_reg == omc_pkg::PS_STBY);
	assign inputs_hiz                        = (ps_reg == omc_pkg::PS_STBY) ||
		(ps_reg == omc_pkg::PS_RESET);
	assign irq                               = irq_reg;
endmodule

// ===== verif/omc_partner.sv
// Far-side model: strap wiring and wake drive of the host board
module omc_partner (
	input  wire logic       pclk,
	input  wire logic       fault_indicator_n,
	output logic            mcu_mode_strap,
	output logic            mcu_mode_strap_open,
	output logic            interface_or_reference_strap,
	output logic            interface_or_reference_strap_open,
	output logic            wake_control_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	int fault_cycles = 0;
	// Board starts tied off, MCU mode with I2C, awake
	initial
	begin
		mcu_mode_strap = 1'b1;
		interface_or_reference_strap = 1'b1;
		mcu_mode_strap_open = 1'b0;
		interface_or_reference_strap_open = 1'b0;
		wake_control_pin = 1'b1;
	end
	// Straps change whenever a test calls set, also mid-test, launched after an edge
	task set(input logic m, input logic s, input logic [1:0] o, input logic w);
		@(posedge pclk);
		mcu_mode_strap <= m;
		interface_or_reference_strap <= s;
		mcu_mode_strap_open <= o[1];
		interface_or_reference_strap_open <= o[0];
		wake_control_pin <= w;
	endtask
	// Host learns of strap faults only from the fault line
	always @(posedge pclk)
		if (fault_indicator_n === 1'b0)
			fault_cycles++;
endmodule

// ===== verif/omc_props.sv
// Port-level assertions for the operating mode control block
module omc_props (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic [11:0] paddr,
	input wire logic        pslverr,
	input wire logic        mcu_mode_strap,
	input wire logic        mcu_mode_strap_open,
	input wire logic        interface_or_reference_strap,
	input wire logic        interface_or_reference_strap_open,
	input wire logic [1:0]  overcurrent_detect,
	input wire logic        wake_control_pin,
	input wire logic        fault_indicator_n,
	input wire logic [1:0]  laser_on,
	input wire logic        mcu_mode,
	input wire logic        ref_half_volt,
	input wire logic        host_if_i2c,
	input wire logic        host_if_spi,
	input wire logic [1:0]  power_loop_mode,
	input wire logic [1:0]  current_loop_mode,
	input wire logic [1:0]  programmable_monitor_resistor_off,
	input wire logic [15:0] overcurrent_threshold,
	input wire logic        standby,
	input wire logic        inputs_hiz
);
	logic [2:0] up_reg;
	logic [2:0] up_next;
	logic       up;
	logic       open_any;
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// Settle counter: synchroniser history is stale right after reset
	always_comb
		up_next = (up_reg == 3'h7) ? up_reg : up_reg + 3'h1;
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			up_reg <= 3'h0;
		else
			up_reg <= up_next;
	assign up = (up_reg == 3'h7);
	assign open_any = mcu_mode_strap_open | interface_or_reference_strap_open;
	// Pin to output latency is three edges, four where a channel trip feeds the fault line
	mode_sel_a: assert property (up |-> mcu_mode == $past(mcu_mode_strap, 3))
		else $error("mode output does not follow mode strap");
	ref_sel_a: assert property (up && !mcu_mode |->
		ref_half_volt == $past(interface_or_reference_strap, 3))
		else $error("reference select wrong in standalone");
	host_if_a: assert property (up && mcu_mode |-> {host_if_i2c, host_if_spi} ==
		{$past(interface_or_reference_strap, 3), !$past(interface_or_reference_strap, 3)})
		else $error("host interface select wrong");
	open_fault_a: assert property (up && $past(open_any, 3) |-> !fault_indicator_n)
		else $error("open strap not flagged");
	open_block_a: assert property (up && $past(open_any, 3) |-> laser_on == 2'b00)
		else $error("laser on with open strap");
	standalone_cfg_a: assert property (up && !mcu_mode |-> {power_loop_mode, current_loop_mode,
		programmable_monitor_resistor_off} == 6'h33 && overcurrent_threshold == 16'hFFFF)
		else $error("standalone settings not forced");
	stby_hiz_a: assert property (standby |-> inputs_hiz)
		else $error("inputs not high impedance in standby");
	wake_hold_a: assert property (up && standby && !$past(wake_control_pin, 2) |=> standby)
		else $error("standby left without wake");
	trip_off_a: assert property (up && $past(overcurrent_detect[0], 4) |->
		!laser_on[0] && !fault_indicator_n)
		else $error("channel 0 not off after overcurrent");
	slverr_map_a: assert property (psel && penable && paddr == 12'h018 |-> pslverr)
		else $error("unmapped access without error");
	cover property (up && !fault_indicator_n);
	cover property (standby);
	cover property (laser_on == 2'b11);
endmodule

bind omc_top omc_props omc_props_inst (.pclk, .presetn, .psel, .penable, .paddr, .pslverr,
	.mcu_mode_strap, .mcu_mode_strap_open, .interface_or_reference_strap,
	.interface_or_reference_strap_open, .overcurrent_detect, .wake_control_pin,
	.fault_indicator_n, .laser_on, .mcu_mode, .ref_half_volt, .host_if_i2c, .host_if_spi,
	.power_loop_mode, .current_loop_mode, .programmable_monitor_resistor_off,
	.overcurrent_threshold, .standby, .inputs_hiz);

// ===== verif/tb.sv
// Self-checking bench for the operating mode control block
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [3:0]  pstrb = 4'hF;
	logic        pready, pslverr, err;
	logic        mcu_mode_strap, mcu_mode_strap_open, interface_or_reference_strap;
	logic        interface_or_reference_strap_open, wake_control_pin;
	logic [1:0]  channel_enable_pin = 2'b00, overcurrent_detect = 2'b00;
	logic        overtemp_detect = 1'b0, power_down_detect = 1'b0;
	logic        fault_indicator_n, mcu_mode, ref_half_volt, host_if_i2c, host_if_spi;
	logic        standby, inputs_hiz, irq;
	logic [1:0]  laser_on, power_loop_mode, current_loop_mode, programmable_monitor_resistor_off;
	logic [15:0] overcurrent_threshold;
	int          n_errors = 0;
	int          compares = 0;
	// 125 MHz clock
	always #4 pclk = ~pclk;
	omc_top omc_top_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
		.prdata, .pready, .pslverr, .mcu_mode_strap, .mcu_mode_strap_open,
		.interface_or_reference_strap, .interface_or_reference_strap_open, .channel_enable_pin,
		.overcurrent_detect, .overtemp_detect, .power_down_detect, .wake_control_pin,
		.fault_indicator_n, .laser_on, .mcu_mode, .ref_half_volt, .host_if_i2c, .host_if_spi,
		.power_loop_mode, .current_loop_mode, .programmable_monitor_resistor_off,
		.overcurrent_threshold, .standby, .inputs_hiz, .irq);
	omc_partner omc_partner_inst (.pclk, .fault_indicator_n, .mcu_mode_strap,
		.mcu_mode_strap_open, .interface_or_reference_strap,
		.interface_or_reference_strap_open, .wake_control_pin);
	// Wait, then step past the edge so registered outputs have landed
	task wt(input int n);
		repeat (n) @(posedge pclk);
		#1;
	endtask
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e)
		begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	// One APB transfer, request held until pready is seen high
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 50)
		begin
			n++;
			@(posedge pclk);
		end
		if (n == 50)
			n_errors++;
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task summarize();
		$display("mismatches %0d comparisons %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// Reset values and an unmapped word
	task t_regs();
		apb(1'b0, omc_pkg::ADDR_CTRL, 32'h0);
		chk("ctrl reset", 32'(omc_pkg::CTRL_RESET), rd);
		apb(1'b0, omc_pkg::ADDR_THRESH, 32'h0);
		chk("thresh reset", 32'(omc_pkg::THRESH_RESET), rd);
		apb(1'b0, omc_pkg::ADDR_IRQ_EN, 32'h0);
		chk("irq_en reset", 32'h0, rd);
		apb(1'b0, 12'h018, 32'h0);
		chk("unmapped pslverr", 32'h1, 32'(err));
		$display("test regs done");
	endtask
	// Every mode and select strap combination with both straps closed, with programmed values that standalone must override
	task t_mode();
		logic m;
		logic s;
		apb(1'b1, omc_pkg::ADDR_CTRL, 32'h00000017);
		apb(1'b1, omc_pkg::ADDR_THRESH, 32'h00001234);
		for (int i = 0; i < 4; i++)
		begin
			m = i[1];
			s = i[0];
			omc_partner_inst.set(m, s, 2'b00, 1'b1);
			wt(4);
			chk("mcu_mode", 32'(m), 32'(mcu_mode));
			chk("ref_half_volt", 32'(!m && s), 32'(ref_half_volt));
			chk("host_if", 32'({m && s, m && !s}), 32'({host_if_i2c, host_if_spi}));
			chk("loop modes", m ? 32'h9 : 32'hC, 32'({power_loop_mode, current_loop_mode}));
			chk("plr off", m ? 32'h1 : 32'h3, 32'(programmable_monitor_resistor_off));
			chk("threshold", m ? 32'h1234 : 32'hFFFF, 32'(overcurrent_threshold));
		end
		$display("test mode done");
	endtask
	// Open straps block lasers, hold fault low, raise and mask the interrupt
	task t_open();
		apb(1'b1, omc_pkg::ADDR_CTRL, 32'h0);
		apb(1'b1, omc_pkg::ADDR_IRQ_EN, 32'h1);
		@(posedge pclk);
		channel_enable_pin <= 2'b11;
		wt(4);
		chk("laser on", 32'h3, 32'(laser_on));
		chk("fault_n idle", 32'h1, 32'(fault_indicator_n));
		omc_partner_inst.set(1'b1, 1'b1, 2'b10, 1'b1);
		wt(6);
		chk("open laser", 32'h0, 32'(laser_on));
		chk("open fault_n", 32'h0, 32'(fault_indicator_n));
		chk("open irq", 32'h1, 32'(irq));
		apb(1'b0, omc_pkg::ADDR_STATUS, 32'h0);
		chk("status read", 32'h1, 32'(rd[omc_pkg::ST_MOPEN]));
		apb(1'b1, omc_pkg::ADDR_IRQ_EN, 32'h0);
		wt(2);
		chk("masked irq", 32'h0, 32'(irq));
		omc_partner_inst.set(1'b1, 1'b1, 2'b01, 1'b1);
		wt(6);
		chk("sel open fault_n", 32'h0, 32'(fault_indicator_n));
		omc_partner_inst.set(1'b1, 1'b1, 2'b00, 1'b1);
		wt(6);
		chk("closed laser", 32'h3, 32'(laser_on));
		chk("closed fault_n", 32'h1, 32'(fault_indicator_n));
		chk("host saw fault", 32'h1, 32'(omc_partner_inst.fault_cycles > 0));
		apb(1'b1, omc_pkg::ADDR_IRQ_CLR, 32'h3F);
		apb(1'b0, omc_pkg::ADDR_IRQ_ST, 32'h0);
		chk("irq cleared", 32'h0, rd);
		$display("test open done");
	endtask
	// Overcurrent pulse latches off channel 0 until its enable is cycled
	task t_trip();
		@(posedge pclk);
		overcurrent_detect <= 2'b01;
		@(posedge pclk);
		overcurrent_detect <= 2'b00;
		wt(5);
		chk("trip laser", 32'h2, 32'(laser_on));
		chk("trip fault_n", 32'h0, 32'(fault_indicator_n));
		wt(8);
		chk("trip held", 32'h2, 32'(laser_on));
		@(posedge pclk);
		channel_enable_pin <= 2'b10;
		wt(4);
		@(posedge pclk);
		channel_enable_pin <= 2'b11;
		wt(4);
		chk("rearm laser", 32'h3, 32'(laser_on));
		chk("rearm fault_n", 32'h1, 32'(fault_indicator_n));
		apb(1'b0, omc_pkg::ADDR_IRQ_ST, 32'h0);
		chk("trip event", 32'h1, 32'(rd[omc_pkg::EV_TRIP0]));
		$display("test trip done");
	endtask
	// Standby keeps settings, floats inputs, ends only on wake
	task t_stby();
		apb(1'b1, omc_pkg::ADDR_THRESH, 32'h0000A55A);
		omc_partner_inst.set(1'b1, 1'b1, 2'b00, 1'b0);
		wt(5);
		chk("standby", 32'h1, 32'(standby));
		chk("hiz", 32'h1, 32'(inputs_hiz));
		apb(1'b0, omc_pkg::ADDR_THRESH, 32'h0);
		chk("thresh in standby", 32'hA55A, rd);
		omc_partner_inst.set(1'b1, 1'b1, 2'b00, 1'b1);
		wt(6);
		chk("awake", 32'h0, 32'(standby));
		chk("hiz awake", 32'h0, 32'(inputs_hiz));
		chk("thresh kept", 32'hA55A, 32'(overcurrent_threshold));
		chk("laser after wake", 32'h3, 32'(laser_on));
		apb(1'b0, omc_pkg::ADDR_CTRL, 32'h0);
		chk("ctrl kept", 32'h0, rd);
		$display("test standby done");
	endtask
	// Power-down and overtemperature pull fault low; overtemperature latches like a trip
	task t_pdn();
		@(posedge pclk);
		power_down_detect <= 1'b1;
		wt(4);
		chk("pdn laser", 32'h0, 32'(laser_on));
		chk("pdn fault_n", 32'h0, 32'(fault_indicator_n));
		@(posedge pclk);
		power_down_detect <= 1'b0;
		overtemp_detect <= 1'b1;
		wt(4);
		chk("ovt fault_n", 32'h0, 32'(fault_indicator_n));
		@(posedge pclk);
		overtemp_detect <= 1'b0;
		wt(4);
		chk("ovt held", 32'h0, 32'(laser_on));
		@(posedge pclk);
		channel_enable_pin <= 2'b00;
		wt(4);
		@(posedge pclk);
		channel_enable_pin <= 2'b11;
		wt(4);
		chk("ovt rearm laser", 32'h3, 32'(laser_on));
		chk("ovt rearm fault_n", 32'h1, 32'(fault_indicator_n));
		$display("test power-down done");
	endtask
	// Watchdog far beyond the under two hundred cycles the tests need
	initial
	begin
		#200000;
		n_errors++;
		summarize();
	end
	initial
	begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_mode();
		t_open();
		t_trip();
		t_stby();
		t_pdn();
		summarize();
	end
endmodule
